//--- pkg/pmbp_params.svh
`ifndef PMBP_PARAMS_SVH
`define PMBP_PARAMS_SVH

// user store address width and size
`define PMBP_AW 13
`define PMBP_USER_BYTES 32'h0000_2000
// fixed program region at the top of code space
`define PMBP_ROM_BASE 16'hf000
`define PMBP_ROM_AW 12
// configuration bytes and their RAM image
`define PMBP_CFG_LAST 6'h2f
`define PMBP_CFG_RAM_BASE 8'h30
`define PMBP_GRP_LAST 2'h2
// fuse location and store selection probe
`define PMBP_FUSE_ADDR 13'h1fcf
`define PMBP_SEL_ADDR 13'h0000
`define PMBP_BLANK_LO 8'h00
`define PMBP_BLANK_HI 8'hff

`endif

//--- pkg/pmbp_pkg.sv
package pmbp_pkg;

  // host opcode classes, already decoded from the serial link
  typedef enum logic [1:0] {
    HOP_READ = 2'h0,
    HOP_WRITE = 2'h1,
    HOP_PROGRAMMING_ENABLE_ON = 2'h2,
    HOP_PROGRAMMING_ENABLE_OFF = 2'h3
  } pmbp_hop_t;

  // cpu fetch sequencer
  typedef enum logic [3:0] {
    CF_IDLE = 4'h1,
    CF_ROM = 4'h2,
    CF_EE = 4'h4,
    CF_ANS = 4'h8
  } pmbp_cf_t;

  // power-up sequencer
  typedef enum logic [2:0] {
    BT_PROBE = 3'h1,
    BT_CFG = 3'h2,
    BT_DONE = 3'h4
  } pmbp_bt_t;

endpackage

//--- pkg/pmbp_mem_if.sv
`timescale 1ns/10ps
`include "pmbp_params.svh"

interface pmbp_mem_if;
  // byte read request from the power-up sequencer
  logic req;
  logic src_ee;
  logic [`PMBP_AW-1:0] addr;
  logic ack;
  logic [7:0] data;
  // configuration word output and selection result
  logic cfg_we;
  logic [7:0] cfg_addr;
  logic [23:0] cfg_data;
  logic sel_ee;
  logic done;

  modport boot (
    output req, src_ee, addr, cfg_we, cfg_addr, cfg_data, sel_ee, done,
    input ack, data
  );
  modport store (
    input req, src_ee, addr, cfg_we, cfg_addr, cfg_data, sel_ee, done,
    output ack, data
  );
endinterface

//--- rtl/pmbp_boot.sv
`timescale 1ns/10ps
`include "pmbp_params.svh"

module pmbp_boot (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // request side toward the stores
  pmbp_mem_if.boot mem
);
  import pmbp_pkg::*;

  // ********************************
  // state
  // ********************************
  pmbp_bt_t st_q;
  logic sel_ee_q;
  logic [5:0] idx_q;
  logic [1:0] grp_q;
  logic [15:0] part_q;
  logic [3:0] wcnt_q;
  logic cfg_we_q;
  logic [7:0] cfg_addr_q;
  logic [23:0] cfg_data_q;

  // ********************************
  // request outputs
  // ********************************
  // probe always asks the external store at address 0
  assign mem.req = (st_q != BT_DONE);
  assign mem.src_ee = (st_q == BT_PROBE) ? 1'b1 : sel_ee_q;
  assign mem.addr = (st_q == BT_PROBE) ? `PMBP_SEL_ADDR : `PMBP_AW'(idx_q);
  assign mem.sel_ee = sel_ee_q;
  assign mem.done = (st_q == BT_DONE);
  assign mem.cfg_we = cfg_we_q;
  assign mem.cfg_addr = cfg_addr_q;
  assign mem.cfg_data = cfg_data_q;

  // sequencer: probe once, then walk the configuration bytes
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= BT_PROBE;
      idx_q <= 6'h00;
    end else if (mem.ack) begin
      unique case (st_q)
        BT_PROBE: begin
          st_q <= BT_CFG;
          idx_q <= 6'h00;
        end
        BT_CFG: begin
          idx_q <= idx_q + 6'h01;
          if (idx_q == `PMBP_CFG_LAST) begin
            st_q <= BT_DONE;
          end
        end
        BT_DONE: begin
          st_q <= BT_DONE;
        end
      endcase
    end
  end

  // store selection, decided only on the probe answer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_ee_q <= 1'b0;
    end else if (mem.ack && st_q == BT_PROBE) begin
      // blank probe keeps the internal store
      sel_ee_q <= (mem.data != `PMBP_BLANK_LO) && (mem.data != `PMBP_BLANK_HI);
    end
  end

  // pack three bytes, first byte on top, into one word
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      grp_q <= 2'h0;
      part_q <= 16'h0000;
      wcnt_q <= 4'h0;
      cfg_we_q <= 1'b0;
      cfg_addr_q <= 8'h00;
      cfg_data_q <= 24'h000000;
    end else begin
      cfg_we_q <= 1'b0;
      if (mem.ack && st_q == BT_CFG) begin
        part_q <= {part_q[7:0], mem.data};
        if (grp_q == `PMBP_GRP_LAST) begin
          grp_q <= 2'h0;
          cfg_we_q <= 1'b1;
          cfg_data_q <= {part_q, mem.data};
          cfg_addr_q <= `PMBP_CFG_RAM_BASE + {4'h0, wcnt_q};
          wcnt_q <= wcnt_q + 4'h1;
        end else begin
          grp_q <= grp_q + 2'h1;
        end
      end
    end
  end

endmodule

//--- rtl/pmbp_top.sv
`timescale 1ns/10ps
`include "pmbp_params.svh"

module pmbp_top #(
  parameter int unsigned DEPTH = `PMBP_USER_BYTES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // host access port
  input wire logic host_req_i,
  input wire pmbp_pkg::pmbp_hop_t host_op_i,
  input wire logic [`PMBP_AW-1:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic host_ack_o,
  output logic [7:0] host_rdata_o,
  output logic host_refused_o,
  // status
  output logic programming_enable_enable_o,
  output logic read_protected_o,
  output logic protect_done_o,
  output logic boot_done_o,
  output logic ext_store_o,
  // cpu fetch port
  input wire logic cpu_req_i,
  input wire logic [15:0] cpu_addr_i,
  output logic cpu_ack_o,
  output logic [7:0] cpu_rdata_o,
  // fixed program region
  output logic [`PMBP_ROM_AW-1:0] rom_addr_o,
  input wire logic [7:0] rom_data_i,
  // external store controller
  output logic ee_req_o,
  output logic [`PMBP_AW-1:0] ee_addr_o,
  input wire logic ee_ack_i,
  input wire logic [7:0] ee_data_i,
  // configuration register writes
  output logic cfg_we_o,
  output logic [7:0] cfg_addr_o,
  output logic [23:0] cfg_data_o
);
  import pmbp_pkg::*;

  // ********************************
  // declarations
  // ********************************
  logic [7:0] otp_q [DEPTH];
  logic programming_enable_en_q;
  logic prot_q;
  logic armed_q;
  logic done_q;
  logic host_ack_q;
  logic host_ref_q;
  logic [7:0] host_rdata_q;
  logic host_rd;
  logic host_wr;
  logic host_fuse;
  logic fuse_blank;
  logic otp_we;
  logic [7:0] host_word;
  logic b_ack_q;
  logic [7:0] b_data_q;
  logic b_start_otp;
  logic b_start_ee;
  logic ee_req_q;
  logic ee_own_cpu_q;
  logic [`PMBP_AW-1:0] ee_addr_q;
  pmbp_cf_t cf_q;
  logic [15:0] cf_addr_q;
  logic [7:0] cf_data_q;
  logic cf_take;
  logic cf_user;
  logic cf_rom;
  logic cf_start_ee;

  pmbp_mem_if mem ();

  // ********************************
  // store read helper
  // ********************************
  // locations past the built depth read as blank
  function automatic logic [7:0] otp_rd(input logic [`PMBP_AW-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (32'(a) < DEPTH) begin
      v = otp_q[a];
    end
    return v;
  endfunction

  // ********************************
  // host decode
  // ********************************
  assign host_rd = host_req_i && (host_op_i == HOP_READ);
  assign host_wr = host_req_i && (host_op_i == HOP_WRITE);
  assign host_fuse = (host_addr_i == `PMBP_FUSE_ADDR);
  // a write lands only with programming enabled
  assign otp_we = host_wr && programming_enable_en_q;
  // store lookups follow every write, not only address changes
  always_comb begin
    fuse_blank = (otp_rd(`PMBP_FUSE_ADDR) == 8'h00);
    // protected reads give zero instead of content
    host_word = prot_q ? 8'h00 : otp_rd(host_addr_i);
  end

  // ********************************
  // one-time store
  // ********************************
  // writes can only set bits, only reset clears them
  for (genvar g = 0; g < DEPTH; g++) begin : g_cell
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        otp_q[g] <= 8'h00;
      end else if (otp_we && 32'(host_addr_i) == g) begin
        otp_q[g] <= otp_q[g] | host_wdata_i;
      end
    end
  end

  // ********************************
  // programming enable
  // ********************************
  // set only by the dedicated ON opcode, cleared by the OFF opcode or by reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      programming_enable_en_q <= 1'b0;
    end else if (host_req_i && host_op_i == HOP_PROGRAMMING_ENABLE_ON) begin
      programming_enable_en_q <= 1'b1;
    end else if (host_req_i && host_op_i == HOP_PROGRAMMING_ENABLE_OFF) begin
      programming_enable_en_q <= 1'b0;
    end
  end

  // ********************************
  // read protection
  // ********************************
  // protected from reset, unlocked by a blank fuse read
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prot_q <= 1'b1;
    end else if (host_rd && host_fuse) begin
      if (armed_q) begin
        prot_q <= 1'b1;
      end else if (fuse_blank) begin
        prot_q <= 1'b0;
      end
    end
  end

  // lock arms on an accepted nonzero fuse write
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      armed_q <= 1'b0;
    end else if (otp_we && host_fuse && host_wdata_i != 8'h00) begin
      armed_q <= 1'b1;
    end else if (host_rd && host_fuse) begin
      armed_q <= 1'b0;
    end
  end

  // lock counts as complete only after the follow-up read
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_q <= 1'b0;
    end else if (host_rd && host_fuse && armed_q) begin
      done_q <= 1'b1;
    end
  end

  // ********************************
  // host answer
  // ********************************
  // every request answered on the next cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_ack_q <= 1'b0;
      host_ref_q <= 1'b0;
      host_rdata_q <= 8'h00;
    end else begin
      host_ack_q <= host_req_i;
      host_ref_q <= (host_wr && !programming_enable_en_q) ||
                    (host_rd && prot_q && !(host_fuse && fuse_blank));
      if (host_rd) begin
        host_rdata_q <= host_word;
      end
    end
  end

  // ********************************
  // power-up sequencer
  // ********************************
  pmbp_boot u_boot (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .mem(mem.boot)
  );

  // internal store answers the sequencer directly
  assign b_start_otp = mem.req && !mem.src_ee && !b_ack_q && !ee_req_q;
  assign b_start_ee = mem.req && mem.src_ee && !b_ack_q && !ee_req_q;
  assign mem.ack = b_ack_q;
  assign mem.data = b_data_q;

  // answers to sequencer reads from either store
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      b_ack_q <= 1'b0;
      b_data_q <= 8'h00;
    end else begin
      b_ack_q <= 1'b0;
      if (b_start_otp) begin
        b_ack_q <= 1'b1;
        b_data_q <= otp_rd(mem.addr);
      end else if (ee_req_q && ee_ack_i && !ee_own_cpu_q) begin
        b_ack_q <= 1'b1;
        b_data_q <= ee_data_i;
      end
    end
  end

  // ********************************
  // cpu fetch decode
  // ********************************
  assign cf_take = (cf_q == CF_IDLE) && cpu_req_i && mem.done;
  assign cf_user = (32'(cpu_addr_i) < DEPTH);
  assign cf_rom = (cpu_addr_i >= `PMBP_ROM_BASE);
  assign cf_start_ee = cf_take && cf_user && mem.sel_ee;

  // ********************************
  // external store port
  // ********************************
  // one outstanding read, owned by sequencer or cpu
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ee_req_q <= 1'b0;
      ee_own_cpu_q <= 1'b0;
      ee_addr_q <= `PMBP_SEL_ADDR;
    end else if (ee_req_q) begin
      if (ee_ack_i) begin
        ee_req_q <= 1'b0;
      end
    end else if (b_start_ee) begin
      ee_req_q <= 1'b1;
      ee_own_cpu_q <= 1'b0;
      ee_addr_q <= mem.addr;
    end else if (cf_start_ee) begin
      ee_req_q <= 1'b1;
      ee_own_cpu_q <= 1'b1;
      ee_addr_q <= cpu_addr_i[`PMBP_AW-1:0];
    end
  end

  // ********************************
  // cpu fetch sequencer
  // ********************************
  // fetches wait until the power-up copy is done
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cf_q <= CF_IDLE;
    end else begin
      unique case (cf_q)
        CF_IDLE: begin
          if (cf_start_ee) begin
            cf_q <= CF_EE;
          end else if (cf_take && cf_rom) begin
            cf_q <= CF_ROM;
          end else if (cf_take) begin
            cf_q <= CF_ANS;
          end
        end
        CF_ROM: begin
          cf_q <= CF_ANS;
        end
        CF_EE: begin
          if (ee_ack_i) begin
            cf_q <= CF_ANS;
          end
        end
        CF_ANS: begin
          cf_q <= CF_IDLE;
        end
      endcase
    end
  end

  // fetch address and data per region
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cf_addr_q <= 16'h0000;
      cf_data_q <= 8'h00;
    end else if (cf_take) begin
      cf_addr_q <= cpu_addr_i;
      // reserved gap reads as zero
      cf_data_q <= cf_user ? otp_rd(cpu_addr_i[`PMBP_AW-1:0]) : 8'h00;
    end else if (cf_q == CF_ROM) begin
      cf_data_q <= rom_data_i;
    end else if (cf_q == CF_EE && ee_ack_i) begin
      cf_data_q <= ee_data_i;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign host_ack_o = host_ack_q;
  assign host_rdata_o = host_rdata_q;
  assign host_refused_o = host_ref_q;
  assign programming_enable_enable_o = programming_enable_en_q;
  assign read_protected_o = prot_q;
  assign protect_done_o = done_q;
  assign boot_done_o = mem.done;
  assign ext_store_o = mem.sel_ee;
  assign cpu_ack_o = (cf_q == CF_ANS);
  assign cpu_rdata_o = cf_data_q;
  assign rom_addr_o = cf_addr_q[`PMBP_ROM_AW-1:0];
  assign ee_req_o = ee_req_q;
  assign ee_addr_o = ee_addr_q;
  assign cfg_we_o = mem.cfg_we;
  assign cfg_addr_o = mem.cfg_addr;
  assign cfg_data_o = mem.cfg_data;

endmodule

//--- verif/pmbp_top_props.sv
`timescale 1ns/10ps
`include "pmbp_params.svh"
// ********************
// port checker
// ********************
module pmbp_top_props #(
  parameter int unsigned DEPTH = `PMBP_USER_BYTES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // host port
  input wire logic host_req_i,
  input wire pmbp_pkg::pmbp_hop_t host_op_i,
  input wire logic [`PMBP_AW-1:0] host_addr_i,
  input wire logic host_ack_o,
  input wire logic [7:0] host_rdata_o,
  input wire logic host_refused_o,
  // status
  input wire logic programming_enable_enable_o,
  input wire logic read_protected_o,
  input wire logic protect_done_o,
  input wire logic boot_done_o,
  input wire logic ext_store_o,
  // external store and configuration
  input wire logic ee_req_o,
  input wire logic [`PMBP_AW-1:0] ee_addr_o,
  input wire logic ee_ack_i,
  input wire logic cfg_we_o,
  input wire logic [7:0] cfg_addr_o
);
  import pmbp_pkg::*;
  logic fuse_rd;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // host request that reads the fuse location
  assign fuse_rd = host_req_i && host_op_i == HOP_READ && host_addr_i == `PMBP_FUSE_ADDR;
  // host transfer steps
  sequence s_wr_off; host_req_i && host_op_i == HOP_WRITE && !programming_enable_enable_o; endsequence
  sequence s_refuse; host_ack_o && host_refused_o; endsequence
  sequence s_prot_rd; host_req_i && host_op_i == HOP_READ && read_protected_o; endsequence
  property p_wr_refused; s_wr_off |=> s_refuse; endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write taken while off");
  property p_prot_zero; s_prot_rd |=> host_ack_o && host_rdata_o == 8'h00; endproperty
  a_prot_zero: assert property (p_prot_zero) else $error("protected read leaked data");
  property p_unlock; $fell(read_protected_o) |-> $past(fuse_rd); endproperty
  a_unlock: assert property (p_unlock) else $error("unlock without fuse read");
  property p_lock; $rose(protect_done_o) |-> read_protected_o && $past(fuse_rd); endproperty
  a_lock: assert property (p_lock) else $error("lock without fuse read");
  property p_reset_prot; $past(sys_rst_i) |-> read_protected_o; endproperty
  a_reset_prot: assert property (p_reset_prot) else $error("not protected after reset");
  property p_probe; $past(sys_rst_i) |=> ee_req_o && ee_addr_o == `PMBP_SEL_ADDR; endproperty
  a_probe: assert property (p_probe) else $error("no probe of byte zero");
  property p_ee_hold; ee_req_o && !ee_ack_i |=> ee_req_o && $stable(ee_addr_o); endproperty
  a_ee_hold: assert property (p_ee_hold) else $error("store request dropped");
  property p_cfg_range; cfg_we_o |-> cfg_addr_o >= 8'h30 && cfg_addr_o <= 8'h3f; endproperty
  a_cfg_range: assert property (p_cfg_range) else $error("config write out of range");
  property p_sel_hold; boot_done_o && $past(boot_done_o) |-> $stable(ext_store_o); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("store selection changed");
endmodule

bind pmbp_top pmbp_top_props #(.DEPTH(DEPTH)) pmbp_top_props_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .host_req_i(host_req_i), .host_op_i(host_op_i), .host_addr_i(host_addr_i), .host_ack_o(host_ack_o),
  .host_rdata_o(host_rdata_o), .host_refused_o(host_refused_o), .programming_enable_enable_o(programming_enable_enable_o),
  .read_protected_o(read_protected_o), .protect_done_o(protect_done_o), .boot_done_o(boot_done_o),
  .ext_store_o(ext_store_o), .ee_req_o(ee_req_o), .ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i),
  .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o));

//--- verif/pmbp_ee_model.sv
`timescale 1ns/10ps
// ********************
// external store model
// ********************
module pmbp_ee_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the block
  input wire logic req_i,
  input wire logic [12:0] addr_i,
  // byte zero content and answer delay
  input wire logic [7:0] probe_i,
  input wire logic [3:0] lat_i,
  // answer
  output logic ack_o,
  output logic [7:0] data_o
);
  logic [3:0] cnt_q;
  logic [7:0] last_q;
  // answer one request after lat_i idle cycles, never twice for one request
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt_q <= 4'h0;
      last_q <= 8'h00;
    end else begin
      ack_o <= 1'b0;
      if (req_i && !ack_o && cnt_q >= lat_i) begin
        ack_o <= 1'b1;
        cnt_q <= 4'h0;
        last_q <= (addr_i == 13'h0000) ? probe_i : (addr_i[7:0] ^ 8'h5a);
      end else if (req_i && !ack_o) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
  // data line shows the inverse outside the answer cycle
  assign data_o = ack_o ? last_q : ~last_q;
endmodule

//--- verif/tb_program_memory_boot_and_protect.sv
`timescale 1ns/10ps
// ********************
// testbench
// ********************
module tb_program_memory_boot_and_protect;
  import pmbp_pkg::*;
  logic clk_i, sys_rst_i, host_req_i, host_ack_o, host_refused_o, programming_enable_enable_o, read_protected_o;
  logic protect_done_o, boot_done_o, ext_store_o, cpu_req_i, cpu_ack_o, ee_req_o, ee_ack_i, cfg_we_o;
  pmbp_hop_t host_op_i;
  logic [12:0] host_addr_i, ee_addr_o;
  logic [7:0] host_wdata_i, host_rdata_o, cpu_rdata_o, rom_data_i, ee_data_i, cfg_addr_o, ee_probe;
  logic [15:0] cpu_addr_i;
  logic [11:0] rom_addr_o;
  logic [23:0] cfg_data_o;
  logic [23:0] cfg_seen [16];
  logic [3:0] ee_lat;
  int cfg_n, n_errors, tests_run;
  pmbp_top pmbp_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_req_i(host_req_i), .host_op_i(host_op_i),
    .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_ack_o(host_ack_o), .host_rdata_o(host_rdata_o),
    .host_refused_o(host_refused_o), .programming_enable_enable_o(programming_enable_enable_o), .read_protected_o(read_protected_o),
    .protect_done_o(protect_done_o), .boot_done_o(boot_done_o), .ext_store_o(ext_store_o), .cpu_req_i(cpu_req_i),
    .cpu_addr_i(cpu_addr_i), .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o), .rom_addr_o(rom_addr_o),
    .rom_data_i(rom_data_i), .ee_req_o(ee_req_o), .ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i),
    .ee_data_i(ee_data_i), .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o));
  pmbp_ee_model pmbp_ee_model_i (.clk_i(clk_i), .rst_i(sys_rst_i), .req_i(ee_req_o), .addr_i(ee_addr_o),
    .probe_i(ee_probe), .lat_i(ee_lat), .ack_o(ee_ack_i), .data_o(ee_data_i));
  // fixed region content derived from its address
  assign rom_data_i = rom_addr_o[7:0] ^ 8'ha5;
  // clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // record configuration words
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_n <= 0;
    end else if (cfg_we_o === 1'b1) begin
      cfg_seen[cfg_addr_o[3:0]] <= cfg_data_o;
      cfg_n <= cfg_n + 1;
    end
  end
  task end_sim;
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task timeout(input string what);
    n_errors++;
    $display("unexpected %s expected done seen timeout", what);
    end_sim;
  endtask
  // one host request, answer judged in the ack cycle
  task host(input pmbp_hop_t op, input logic [12:0] a, input logic [7:0] wd, input logic [7:0] erd, input logic eref);
    @(negedge clk_i);
    host_req_i = 1'b1;
    host_op_i = op;
    host_addr_i = a;
    host_wdata_i = wd;
    @(negedge clk_i);
    host_req_i = 1'b0;
    chk("host_ack_o", 24'h1, host_ack_o);
    chk("host_refused_o", eref, host_refused_o);
    if (op == HOP_READ) chk("host_rdata_o", erd, host_rdata_o);
  endtask
  // one fetch, request held until ack
  task cpu(input logic [15:0] a, input logic [7:0] e);
    int i;
    @(negedge clk_i);
    cpu_req_i = 1'b1;
    cpu_addr_i = a;
    for (i = 0; i < 50 && cpu_ack_o !== 1'b1; i++) @(negedge clk_i);
    cpu_req_i = 1'b0;
    if (cpu_ack_o !== 1'b1) timeout("cpu_ack_o");
    chk("cpu_rdata_o", e, cpu_rdata_o);
  endtask
  // power-up with a given probe byte, check selection and configuration image
  task t_boot(input logic [7:0] probe, input logic [3:0] lat);
    logic ext;
    int i;
    logic [7:0] b [3];
    ext = (probe != 8'h00) && (probe != 8'hff);
    ee_probe = probe;
    ee_lat = lat;
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    for (i = 0; i < 2000 && boot_done_o !== 1'b1; i++) @(negedge clk_i);
    if (boot_done_o !== 1'b1) timeout("boot_done_o");
    repeat (2) @(negedge clk_i);
    chk("ext_store_o", ext, ext_store_o);
    chk("cfg_n", 24'd16, cfg_n);
    for (i = 0; i < 16; i++) begin
      b[0] = (i == 0) ? probe : (8'(3 * i) ^ 8'h5a);
      b[1] = 8'(3 * i + 1) ^ 8'h5a;
      b[2] = 8'(3 * i + 2) ^ 8'h5a;
      chk("cfg_word", ext ? {b[0], b[1], b[2]} : 24'h0, cfg_seen[i]);
    end
  endtask
  // unlock, refused and accepted writes
  task t_unlock;
    host(HOP_READ, 13'h0005, 8'h00, 8'h00, 1'b1);
    host(HOP_WRITE, 13'h0005, 8'h5a, 8'h00, 1'b1);
    host(HOP_READ, 13'h1fcf, 8'h00, 8'h00, 1'b0);
    chk("read_protected_o", 24'h0, read_protected_o);
    host(HOP_READ, 13'h0005, 8'h00, 8'h00, 1'b0);
    host(HOP_PROGRAMMING_ENABLE_ON, 13'h0000, 8'h00, 8'h00, 1'b0);
    chk("programming_enable_enable_o", 24'h1, programming_enable_enable_o);
    host(HOP_WRITE, 13'h0005, 8'h5a, 8'h00, 1'b0);
    host(HOP_PROGRAMMING_ENABLE_OFF, 13'h0000, 8'h00, 8'h00, 1'b0);
    host(HOP_READ, 13'h0005, 8'h00, 8'h5a, 1'b0);
  endtask
  // fetches from user store, reserved space and fixed region
  task t_fetch;
    cpu(16'h0005, 8'h5a);
    cpu(16'h3000, 8'h00);
    cpu(16'hf123, 8'h86);
    cpu(16'hefff, 8'h00);
  endtask
  // lock, held until reset, by nonzero fuse write then fuse read
  task t_lock;
    host(HOP_PROGRAMMING_ENABLE_ON, 13'h0000, 8'h00, 8'h00, 1'b0);
    host(HOP_WRITE, 13'h1fcf, 8'h01, 8'h00, 1'b0);
    host(HOP_READ, 13'h1fcf, 8'h00, 8'h01, 1'b0);
    chk("protect_done_o", 24'h1, protect_done_o);
    chk("read_protected_o", 24'h1, read_protected_o);
    host(HOP_READ, 13'h0005, 8'h00, 8'h00, 1'b1);
    host(HOP_READ, 13'h1fcf, 8'h00, 8'h00, 1'b1);
  endtask
  // external store after power-up
  task t_ext;
    host(HOP_READ, 13'h0005, 8'h00, 8'h00, 1'b1);
    cpu(16'h0000, 8'h12);
    cpu(16'h0100, 8'h5a);
    cpu(16'h1fff, 8'ha5);
  endtask
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    host_req_i = 1'b0;
    host_op_i = HOP_READ;
    host_addr_i = 13'h0000;
    host_wdata_i = 8'h00;
    cpu_req_i = 1'b0;
    cpu_addr_i = 16'h0000;
    ee_probe = 8'hff;
    ee_lat = 4'h0;
    n_errors = 0;
    tests_run = 0;
    t_boot(8'hff, 4'h0);
    t_unlock;
    t_fetch;
    t_lock;
    t_boot(8'h12, 4'h3);
    t_ext;
    t_boot(8'h00, 4'h1);
    end_sim;
  end
endmodule
